// ==== hdl/dtr_params.svh ====
// Purpose: constants for the discovery table read block
// Assumes: table and timing values fixed by the device
// Notes: definitions only
`ifndef DTR_PARAMS_SVH
`define DTR_PARAMS_SVH
`define DTR_CMD_CODE 8'h5A
`define DTR_ADDR_BITS 24
`define DTR_PTR_W 11
`define DTR_DUMMY_EXT 5'd8
`define DTR_DUMMY_QUAD 5'd10
`define DTR_CMD_BITS 3'd7
`define DTR_ADDR_LAST 5'd23
`define DTR_FILL 8'hFF
`define DTR_SYNC_IDLE 6'h1F
`define DTR_ZERO 8'h00
`define DTR_TBL_LAST 7'h53
`define DTR_PROT_EXT 2'h0
`define DTR_PROT_DUAL 2'h1
`define DTR_PROT_QUAD 2'h2
`endif

// ==== hdl/dtr_pkg.sv ====
// Purpose: types for the discovery table read block
// Assumes: used with dtr_params.svh
// Notes: types only
package dtr_pkg;
   typedef enum logic [2:0] {
      DTR_IDLE = 3'h0,
      DTR_CMD = 3'h1,
      DTR_ADDR = 3'h3,
      DTR_DUMMY = 3'h2,
      DTR_DATA = 3'h6,
      DTR_SKIP = 3'h7
   } dtr_state_e;
   typedef logic [1:0] dtr_prot_t;
endpackage

// ==== hdl/dtr_discovery_read.sv ====
// Purpose: serial discovery-parameter table read, sampled on the system clock
// Assumes: serial clock far slower than clock; host keeps its own rules
// Notes: array reads, program, erase and register commands are not decoded
`timescale 1ns/1ps
`default_nettype none
`include "dtr_params.svh"

// Summary of operation
// - Dummy clocks follow address: 8 extended or dual, 10 quad; no drive.
// - Output table bytes from given address, advancing after each byte.
// - Pointer wraps from table end at 2048 bytes back to zero.
// - Select high at any time stops driving and abandons the operation.
// - Always continuous; burst-wrap setting ignored.
// - Bytes 00h-03h return signature 53h 46h 44h 50h.
// - 04h=00h, 05h=01h, 06h=00h, 07h=FFh.
// - Parameter header 08h-0Fh: 00 00 01 09 30 00 00 FF.
// - Locations 10h through 2Fh return FFh.
// - Byte 30h: erase size 01b, granularity 1, bits 4:3 zero, 111b above.
// - Byte 31h returns 4KB erase opcode 20h.
// - Byte 32h is F1h; byte 33h returns FFh.
// - Density bytes 34h-37h: FFh FFh FFh 07h.
// - 38h holds 1-4-4 dummy 01001b, mode 001b; 39h holds EBh.
// - 3Ah holds 1-1-4 dummy 00111b, mode 001b; 3Bh holds 6Bh.
// - 3Ch holds 1-1-2 dummy 01000b, mode 000b; 3Dh holds 3Bh.
// - 3Eh holds 1-2-2 dummy 00111b, mode 001b; 3Fh holds BBh.
// - 40h reports 2-2-2 and 4-4-4 support, reserved set; 41h-45h FFh.
// - 46h holds 2-2-2 dummy 00111b, mode 001b; 47h BBh; 48h-49h FFh.
// - 4Ah holds 4-4-4 dummy 01001b, mode 001b; 4Bh holds EBh.
// - Erase types: 0Ch/20h, 10h/D8h, then 50h-53h all zero.
// - Address bits are sampled on rising serial clock edges.
module dtr_discovery_read (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire dtr_pkg::dtr_prot_t prot_mode,
   input wire logic burst_wrap_en,
   input wire logic serial_clk,
   input wire logic chip_sel_n,
   input wire logic [3:0] io_lanes_in,
   output logic [3:0] io_lanes_out,
   output logic [3:0] io_lanes_oe,
   output logic busy
);
   import dtr_pkg::*;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [5:0] meta_q;
   logic [5:0] sync_q;
   logic sclk_prev_q;
   logic sclk_rise;
   logic sclk_fall;
   logic sel_n;
   logic [3:0] lanes;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         // Idle pin levels: clock low, select high, so no false edge follows reset
         meta_q <= `DTR_SYNC_IDLE;
         sync_q <= `DTR_SYNC_IDLE;
         sclk_prev_q <= 1'b0;
      end else if (clk_en) begin
         meta_q <= {serial_clk, chip_sel_n, io_lanes_in};
         sync_q <= meta_q;
         sclk_prev_q <= sync_q[5];
      end
   end

   assign sel_n = sync_q[4];
   assign lanes = sync_q[3:0];
   assign sclk_rise = sync_q[5] & ~sclk_prev_q;
   assign sclk_fall = ~sync_q[5] & sclk_prev_q;

   // ----------------------------------------
   // Table contents
   // ----------------------------------------
   function automatic logic [7:0] table_byte(input logic [10:0] a);
      logic [7:0] v;
      v = `DTR_FILL;
      if (a[10:7] == 4'h0) begin
         case (a[6:0])
            7'h00: v = 8'h53;
            7'h01: v = 8'h46;
            7'h02: v = 8'h44;
            7'h03: v = 8'h50;
            7'h04: v = 8'h00;
            7'h05: v = 8'h01;
            7'h06: v = 8'h00;
            7'h08: v = 8'h00;
            7'h09: v = 8'h00;
            7'h0A: v = 8'h01;
            7'h0B: v = 8'h09;
            7'h0C: v = 8'h30;
            7'h0D: v = 8'h00;
            7'h0E: v = 8'h00;
            7'h30: v = 8'hE5;
            7'h31: v = 8'h20;
            7'h32: v = 8'hF1;
            7'h37: v = 8'h07;
            7'h38: v = 8'h29;
            7'h39: v = 8'hEB;
            7'h3A: v = 8'h27;
            7'h3B: v = 8'h6B;
            7'h3C: v = 8'h08;
            7'h3D: v = 8'h3B;
            7'h3E: v = 8'h27;
            7'h3F: v = 8'hBB;
            7'h40: v = 8'hFF;
            7'h46: v = 8'h27;
            7'h47: v = 8'hBB;
            7'h4A: v = 8'h29;
            7'h4B: v = 8'hEB;
            7'h4C: v = 8'h0C;
            7'h4D: v = 8'h20;
            7'h4E: v = 8'h10;
            7'h4F: v = 8'hD8;
            default: begin
               // 07h, 0Fh, 10h-2Fh, 33h-36h, 41h-45h, 48h-49h read FFh
               if (a[6:0] >= 7'h50 && a[6:0] <= `DTR_TBL_LAST) begin
                  v = `DTR_ZERO;
               end
            end
         endcase
      end
      // Everything else stays filler, undefined area above 53h
      return v;
   endfunction

   // ----------------------------------------
   // Command sequencer
   // ----------------------------------------
   dtr_state_e state_q;
   logic [4:0] cnt_q;
   logic [7:0] cmd_q;
   logic [10:0] ptr_q;
   logic [7:0] shift_q;
   logic [2:0] bit_left_q;
   logic [2:0] step;
   logic [4:0] dummy_n;

   // Bits per data clock; burst_wrap_en deliberately unused: continuous only
   always_comb begin
      case (prot_mode)
         `DTR_PROT_DUAL: step = 3'd2;
         `DTR_PROT_QUAD: step = 3'd4;
         default: step = 3'd1;
      endcase
   end

   assign dummy_n = (prot_mode == `DTR_PROT_QUAD) ? `DTR_DUMMY_QUAD : `DTR_DUMMY_EXT;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_q <= DTR_IDLE;
         cnt_q <= 5'd0;
      end else if (clk_en) begin
         if (sel_n) begin
            state_q <= DTR_IDLE;
            cnt_q <= 5'd0;
         end else begin
            case (state_q)
               DTR_IDLE: begin
                  state_q <= DTR_CMD;
                  cnt_q <= 5'd0;
               end
               DTR_CMD: if (sclk_rise) begin
                  cnt_q <= cnt_q + 5'd1;
                  if (cnt_q[2:0] == `DTR_CMD_BITS) begin
                     cnt_q <= 5'd0;
                     // Unknown codes park in skip until select rises
                     state_q <= ({cmd_q[6:0], lanes[0]} == `DTR_CMD_CODE) ?
                        DTR_ADDR : DTR_SKIP;
                  end
               end
               DTR_ADDR: if (sclk_rise) begin
                  cnt_q <= cnt_q + 5'd1;
                  if (cnt_q == `DTR_ADDR_LAST) begin
                     cnt_q <= 5'd0;
                     state_q <= DTR_DUMMY;
                  end
               end
               DTR_DUMMY: if (sclk_rise) begin
                  cnt_q <= cnt_q + 5'd1;
                  if (cnt_q == dummy_n - 5'd1) begin
                     state_q <= DTR_DATA;
                  end
               end
               // Data runs until select rises; there is no length limit
               DTR_DATA: state_q <= DTR_DATA;
               DTR_SKIP: state_q <= DTR_SKIP;
               default: state_q <= DTR_IDLE;
            endcase
         end
      end
   end

   // Command shift register, only fills while the command phase runs
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cmd_q <= 8'h00;
      end else if (clk_en) begin
         if (!sel_n && state_q == DTR_CMD && sclk_rise) begin
            cmd_q <= {cmd_q[6:0], lanes[0]};
         end
      end
   end

   // Read pointer: loaded by address bits, stepped after each byte's last chunk
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ptr_q <= 11'h000;
      end else if (clk_en && !sel_n) begin
         if (state_q == DTR_ADDR && sclk_rise) begin
            // Upper address bits fold away, table is 2048 bytes
            ptr_q <= {ptr_q[9:0], lanes[0]};
         end else if (state_q == DTR_DATA && sclk_fall && bit_left_q == step) begin
            // Eleven bits roll over from the table end to zero
            ptr_q <= ptr_q + 11'd1;
         end
      end
   end

   // ----------------------------------------
   // Byte fetch
   // ----------------------------------------
   // Top bits of a byte on the active lanes, lane zero lowest
   function automatic logic [3:0] lane_chunk(input logic [7:0] b, input logic [2:0] s);
      logic [3:0] c;
      c = 4'h0;
      case (s)
         3'd2: c = {2'b00, b[7:6]};
         3'd4: c = b[7:4];
         default: c = {3'b000, b[7]};
      endcase
      return c;
   endfunction

   // Lanes driven for a given bit step
   function automatic logic [3:0] lane_mask(input logic [2:0] s);
      logic [3:0] m;
      m = 4'h1;
      case (s)
         3'd2: m = 4'h3;
         3'd4: m = 4'hF;
         default: m = 4'h1;
      endcase
      return m;
   endfunction

   logic [7:0] next_byte;
   // Pointer has already stepped when the last chunk of the previous byte left
   assign next_byte = table_byte(ptr_q);

   // ----------------------------------------
   // Output shifter
   // ----------------------------------------
   logic data_on;
   assign data_on = (state_q == DTR_DATA) && !sel_n;

   // bit_left_q counts bits still waiting after the chunk now on the lanes
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         shift_q <= 8'h00;
         bit_left_q <= 3'd0;
         io_lanes_out <= 4'h0;
      end else if (clk_en) begin
         if (!data_on) begin
            bit_left_q <= 3'd0;
            io_lanes_out <= 4'h0;
         end else if (sclk_fall) begin
            if (bit_left_q == 3'd0) begin
               shift_q <= next_byte << step;
               bit_left_q <= 3'd0 - step;
               io_lanes_out <= lane_chunk(next_byte, step);
            end else begin
               shift_q <= shift_q << step;
               bit_left_q <= bit_left_q - step;
               io_lanes_out <= lane_chunk(shift_q, step);
            end
         end
      end
   end

   // Single lane output goes on lane zero; drive starts at the first data fall
   logic drive_q;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         drive_q <= 1'b0;
      end else if (clk_en) begin
         drive_q <= data_on && (sclk_fall || drive_q);
      end
   end

   always_comb begin
      io_lanes_oe = 4'h0;
      if (drive_q && data_on) begin
         io_lanes_oe = lane_mask(step);
      end
   end

   assign busy = (state_q != DTR_IDLE);

endmodule
`default_nettype wire

// ==== bench/dtr_discovery_read_properties.sv ====
// Purpose: port checks for the discovery table read block
// Assumes: serial clock period of at least eight clocks
// Notes: data launch is timed from the falling serial clock
`timescale 1ns/1ps
`default_nettype none
`include "dtr_params.svh"
module dtr_discovery_read_properties (
   input wire logic clock,
   input wire logic sys_rst,
   input wire dtr_pkg::dtr_prot_t prot_mode,
   input wire logic serial_clk,
   input wire logic chip_sel_n,
   input wire logic [3:0] io_lanes_out,
   input wire logic [3:0] io_lanes_oe,
   input wire logic busy
);
   import dtr_pkg::*;
   logic [3:0] since_fall_q;
   // Saturates so a long idle never wraps back into the launch window
   always_ff @(posedge clock) begin
      if (sys_rst || $fell(serial_clk)) begin
         since_fall_q <= 4'h0;
      end else if (since_fall_q != 4'hF) begin
         since_fall_q <= since_fall_q + 4'h1;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence s_desel; chip_sel_n [*6]; endsequence
   sequence s_held; !chip_sel_n [*4]; endsequence
   property p_desel_quiet; s_desel |-> io_lanes_oe == 4'h0; endproperty
   property p_busy_ends; s_desel |-> !busy; endproperty
   property p_oe_lanes;
      (|io_lanes_oe) |-> io_lanes_oe == (prot_mode == `DTR_PROT_QUAD ? 4'hF :
         prot_mode == `DTR_PROT_DUAL ? 4'h3 : 4'h1);
   endproperty
   property p_oe_busy; (|io_lanes_oe) |-> busy; endproperty
   property p_oe_start; $rose(|io_lanes_oe) |-> since_fall_q <= 4'h6; endproperty
   property p_stands; $changed(io_lanes_out) && (|io_lanes_oe) |-> since_fall_q <= 4'h6; endproperty
   property p_streams; (|io_lanes_oe) ##0 s_held |-> (|io_lanes_oe); endproperty
   property p_reset_quiet;
      disable iff (1'b0) sys_rst |=> io_lanes_out == 4'h0 && io_lanes_oe == 4'h0 && !busy;
   endproperty
   a_desel_quiet: assert property (p_desel_quiet) else $error("drive while deselected");
   a_busy_ends: assert property (p_busy_ends) else $error("busy while deselected");
   a_oe_lanes: assert property (p_oe_lanes) else $error("lane width off");
   a_oe_busy: assert property (p_oe_busy) else $error("drive outside a frame");
   a_oe_start: assert property (p_oe_start) else $error("drive not after a fall");
   a_stands: assert property (p_stands) else $error("data moved mid beat");
   a_streams: assert property (p_streams) else $error("stream stopped");
   a_reset_quiet: assert property (p_reset_quiet) else $error("reset not quiet");
endmodule
bind dtr_discovery_read dtr_discovery_read_properties dtr_discovery_read_properties_inst (
   .clock(clock), .sys_rst(sys_rst), .prot_mode(prot_mode), .serial_clk(serial_clk),
   .chip_sel_n(chip_sel_n), .io_lanes_out(io_lanes_out), .io_lanes_oe(io_lanes_oe), .busy(busy));
`default_nettype wire

// ==== bench/dtr_host_model.sv ====
// Purpose: host side of the serial link
// Assumes: serial clock idles low, eight clocks a period
// Notes: released lanes toggle every clock
`timescale 1ns/1ps
`default_nettype none
module dtr_host_model (
   input wire logic clock,
   input wire logic [3:0] io_lanes_out,
   input wire logic [3:0] io_lanes_oe,
   output logic serial_clk,
   output logic chip_sel_n,
   output logic [3:0] io_lanes_in
);
   logic drv_en = 1'b0;
   logic drv_bit = 1'b0;
   logic oe_seen = 1'b0;
   logic [3:0] junk_q = 4'h5;
   initial begin
      serial_clk = 1'b0;
      chip_sel_n = 1'b1;
   end
   // A released lane toggles so a stale level never passes for data
   always @(posedge clock) junk_q <= ~junk_q;
   assign io_lanes_in = (io_lanes_oe & io_lanes_out) |
      (~io_lanes_oe & {junk_q[3:1], drv_en ? drv_bit : junk_q[0]});
   task automatic half();
      repeat (4) begin
         @(negedge clock);
         oe_seen = oe_seen | (|io_lanes_oe);
      end
   endtask
   task automatic beat(output logic [3:0] d);
      half();
      serial_clk = 1'b1;
      half();
      d = io_lanes_out;
      serial_clk = 1'b0;
   endtask
   task automatic start(input logic [7:0] cmd, input logic [23:0] addr, input int dummies);
      logic [31:0] v;
      logic [3:0] d;
      v = {cmd, addr};
      chip_sel_n = 1'b0;
      drv_en = 1'b1;
      for (int i = 31; i >= 0; i--) begin
         drv_bit = v[i];
         beat(d);
      end
      drv_en = 1'b0;
      repeat (dummies) beat(d);
   endtask
   task automatic stop();
      chip_sel_n = 1'b1;
      half();
      half();
   endtask
endmodule
`default_nettype wire

// ==== bench/dtr_discovery_read_bench.sv ====
// Purpose: self-checking bench for the discovery table read block
// Assumes: host model paces the serial clock at 200 ns
// Notes: expected bytes come from the table model below
`timescale 1ns/1ps
`default_nettype none
`include "dtr_params.svh"
module dtr_discovery_read_bench;
   import dtr_pkg::*;
   logic clock;
   logic sys_rst;
   logic burst_wrap_en;
   dtr_prot_t prot_mode;
   logic serial_clk;
   logic chip_sel_n;
   logic busy;
   logic [3:0] io_lanes_in;
   logic [3:0] io_lanes_out;
   logic [3:0] io_lanes_oe;
   int miscompares = 0;
   int checks_done = 0;
   // Address 00h sits in the top byte
   localparam logic [671:0] TBL = {
      224'h53464450000100FF00000109300000FFFFFFFFFFFFFFFFFFFFFFFFFF,
      224'hFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFE520F1FFFFFFFF07,
      224'h29EB276B083B27BBFFFFFFFFFFFF27BBFFFF29EB0C2010D800000000
   };
   dtr_discovery_read dtr_discovery_read_inst (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1),
      .prot_mode(prot_mode), .burst_wrap_en(burst_wrap_en), .serial_clk(serial_clk),
      .chip_sel_n(chip_sel_n), .io_lanes_in(io_lanes_in), .io_lanes_out(io_lanes_out),
      .io_lanes_oe(io_lanes_oe), .busy(busy));
   dtr_host_model dtr_host_model_inst (.clock(clock), .io_lanes_out(io_lanes_out),
      .io_lanes_oe(io_lanes_oe), .serial_clk(serial_clk), .chip_sel_n(chip_sel_n),
      .io_lanes_in(io_lanes_in));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task automatic give_verdict();
      if (miscompares == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Undefined locations past the last entry read as filler
   function automatic logic [7:0] tbl(input int a);
      return a > 'h53 ? 8'hFF : TBL[671 - 8 * a -: 8];
   endfunction
   task automatic read_run(input dtr_prot_t p, input logic [23:0] a, input int n, input int xb,
      input logic [7:0] cmd);
      logic [3:0] d;
      logic [7:0] b;
      int w;
      int ptr;
      prot_mode = p;
      w = p == `DTR_PROT_QUAD ? 4 : p == `DTR_PROT_DUAL ? 2 : 1;
      ptr = int'(a[10:0]);
      dtr_host_model_inst.oe_seen = 1'b0;
      dtr_host_model_inst.start(cmd, a, w == 4 ? 10 : 8);
      check({7'h00, dtr_host_model_inst.oe_seen}, 8'h00);
      for (int k = 0; k < n; k++) begin
         for (int j = 0; j < 8 / w; j++) begin
            dtr_host_model_inst.beat(d);
            b = w == 4 ? {b[3:0], d} : w == 2 ? {b[5:0], d[1:0]} : {b[6:0], d[0]};
         end
         if (cmd == `DTR_CMD_CODE) check(b, tbl(ptr));
         ptr = (ptr + 1) % 2048;
      end
      repeat (xb) dtr_host_model_inst.beat(d);
      if (cmd != `DTR_CMD_CODE) check({7'h00, dtr_host_model_inst.oe_seen}, 8'h00);
      dtr_host_model_inst.stop();
      check({3'h0, busy, io_lanes_oe}, 8'h00);
   endtask
   initial begin
      repeat (100000) @(posedge clock);
      miscompares++;
      give_verdict();
   end
   initial begin
      sys_rst = 1'b1;
      burst_wrap_en = 1'b0;
      prot_mode = `DTR_PROT_EXT;
      void'($urandom(32'h58B86FE5));
      repeat (10) @(negedge clock);
      sys_rst = 1'b0;
      repeat (4) @(negedge clock);
      burst_wrap_en = 1'b1;
      read_run(`DTR_PROT_EXT, 24'h000000, 84, 0, `DTR_CMD_CODE);
      read_run(`DTR_PROT_DUAL, 24'($urandom) | 24'h0007FE, 4, 1, `DTR_CMD_CODE);
      for (int i = 0; i < 6; i++) begin
         burst_wrap_en = 1'($urandom);
         read_run(dtr_prot_t'(i % 3), 24'($urandom) & 24'hFFF87F, 3, i % 3 + 1, `DTR_CMD_CODE);
      end
      read_run(`DTR_PROT_QUAD, 24'h000000, 2, 0, 8'hA5);
      give_verdict();
   end
endmodule
`default_nettype wire
